//--- rtl/iar_routing_top.sv
// Purpose: Routes 58 interrupt sources onto 32 or 24 controller pins.
// Assumes: All sources are on-chip logic on aclk; registers reached over AXI4-Lite.
// Notes: Pin outputs are registered, so routing adds one cycle of latency.
//
// What this block does
// - Each individual source drives at most one pin chosen by its pin number.
// - Map A holds pin numbers of bridge ports 0 to 3, bytes 0 to 3.
// - Map B holds pin numbers of bridge ports 4 to 7, bytes 0 to 3.
// - Map C holds pin numbers of bridge ports 8 to 11, bytes 0 to 3.
// - Internal map steers the host-link and translation-unit interrupts to pins.
// - Each of eleven four-wire groups is reordered by its own swizzle code.
// - Wire A is the low bit and wire D the high bit of a group.
// - Codes 00, 01, 10, 11 give ABCD, BCDA, CDAB, DABC before assignment.
// - Each swizzled group lands on the output group named by its group number.
// - Mode chooses eight output groups of four pins, or six.
// - Several input groups may share one output group.
// - Read-only debug register shows the 32 interrupts entering the controller, with bits 4 to 7 inverted.
// - Group number g selects pins 4*(g-1) up to 4*g-1, wrapping modulo 32.
// - Mode one selects 32 pins, mode zero selects 24 pins.
`timescale 1ns/1ps
`include "iar_regs.svh"
module iar_routing_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [43:0] ext_group_irq,
   input wire logic [11:0] bridge_irq,
   input wire logic host_link_irq,
   input wire logic translation_unit_irq,
   output logic [31:0] irq_pin,
   output logic irq_out
);
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [2:0][31:0] grp_map;
      logic [2:0][31:0] pin_map;
      logic [31:0] int_src_map;
      logic mode_full;
      logic [31:0] pins;
      logic [31:0] evt_status;
      logic [31:0] evt_enable;
   } iar_state_t;

   iar_state_t st_r;
   iar_state_t st_nxt;

   logic wr_en;
   logic [5:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [5:0] rd_idx;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [43:0] swizzled;
   logic [31:0] routed;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      merge = res;
   endfunction

   // A pin number past the end of the active range drives nothing.
   function automatic logic pin_in_range(input iar_pkg::iar_pin_t pin, input logic full);
      pin_in_range = {1'b0, pin} < (full ? `IAR_FULL_PINS : `IAR_REDUCED_PINS);
   endfunction

   // -------------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------------
   iar_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // -------------------------------------------------------------------------
   // Swizzle stage
   // -------------------------------------------------------------------------
   for (genvar g = 0; g < `IAR_NUM_EXT_GROUPS; g++) begin : g_swz
      iar_swizzle u_swz (
         .group_in(ext_group_irq[g*4 +: 4]),
         .swizzle_code(st_r.grp_map[g/4][(g%4)*`IAR_FLD_STRIDE + `IAR_SWZ_LSB +: 2]),
         .group_out(swizzled[g*4 +: 4])
      );
   end

   // -------------------------------------------------------------------------
   // Routing
   // -------------------------------------------------------------------------
   always_comb begin
      iar_pkg::iar_grp_t gnum;
      iar_pkg::iar_pin_t pnum;
      iar_pkg::iar_grp_t gidx;
      logic [3:0] ngroups;
      gnum = '0;
      gidx = '0;
      pnum = '0;
      ngroups = st_r.mode_full ? `IAR_FULL_GROUPS : `IAR_REDUCED_GROUPS;
      routed = '0;
      for (int g = 0; g < `IAR_NUM_EXT_GROUPS; g++) begin
         gnum = st_r.grp_map[g/4][(g%4)*`IAR_FLD_STRIDE + `IAR_GRP_LSB +: 3];
         // Group number zero wraps to the last output group, so the 3-bit field
         // still reaches all eight groups in full mode.
         gidx = gnum - 3'h1;
         if ({1'b0, gidx} < ngroups) begin
            routed[{gidx, 2'b00} +: 4] |= swizzled[g*4 +: 4];
         end
      end
      for (int p = 0; p < `IAR_NUM_BRIDGES; p++) begin
         pnum = st_r.pin_map[p/4][(p%4)*`IAR_FLD_STRIDE + `IAR_PIN_LSB +: 5];
         if (pin_in_range(pnum, st_r.mode_full)) begin
            routed[pnum] = routed[pnum] | bridge_irq[p];
         end
      end
      pnum = st_r.int_src_map[`IAR_HOST_LINK_LSB +: 5];
      if (pin_in_range(pnum, st_r.mode_full)) begin
         routed[pnum] = routed[pnum] | host_link_irq;
      end
      pnum = st_r.int_src_map[`IAR_XLATE_LSB +: 5];
      if (pin_in_range(pnum, st_r.mode_full)) begin
         routed[pnum] = routed[pnum] | translation_unit_irq;
      end
   end

   // -------------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------------
   always_comb begin
      rd_ok = 1'b1;
      case (rd_idx)
         `IAR_IDX_GRP_MAP_0: rd_data = st_r.grp_map[0];
         `IAR_IDX_GRP_MAP_1: rd_data = st_r.grp_map[1];
         `IAR_IDX_GRP_MAP_2: rd_data = st_r.grp_map[2];
         `IAR_IDX_FEATURE: rd_data = {31'h0000_0000, st_r.mode_full};
         `IAR_IDX_PIN_MAP_A: rd_data = st_r.pin_map[0];
         `IAR_IDX_PIN_MAP_B: rd_data = st_r.pin_map[1];
         `IAR_IDX_PIN_MAP_C: rd_data = st_r.pin_map[2];
         `IAR_IDX_INT_SRC_MAP: rd_data = st_r.int_src_map;
         `IAR_IDX_DEBUG_STS: rd_data = st_r.pins ^ `IAR_DBG_INV_MASK;
         `IAR_IDX_EVT_STATUS: rd_data = st_r.evt_status;
         `IAR_IDX_EVT_ENABLE: rd_data = st_r.evt_enable;
         `IAR_IDX_EVT_CLEAR: rd_data = `IAR_WORD_ZERO;
         default: begin
            rd_data = `IAR_WORD_ZERO;
            rd_ok = 1'b0;
         end
      endcase
   end

   // Debug status is read-only, so a write to it is refused with an error.
   always_comb begin
      case (wr_idx)
         `IAR_IDX_GRP_MAP_0, `IAR_IDX_GRP_MAP_1, `IAR_IDX_GRP_MAP_2, `IAR_IDX_FEATURE,
         `IAR_IDX_PIN_MAP_A, `IAR_IDX_PIN_MAP_B, `IAR_IDX_PIN_MAP_C, `IAR_IDX_INT_SRC_MAP,
         `IAR_IDX_EVT_ENABLE, `IAR_IDX_EVT_CLEAR: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      logic [31:0] clr;
      clr = '0;
      st_nxt = st_r;
      if (wr_en) begin
         case (wr_idx)
            `IAR_IDX_GRP_MAP_0: st_nxt.grp_map[0] = merge(st_r.grp_map[0], wr_data, wr_strb);
            `IAR_IDX_GRP_MAP_1: st_nxt.grp_map[1] = merge(st_r.grp_map[1], wr_data, wr_strb);
            `IAR_IDX_GRP_MAP_2: st_nxt.grp_map[2] = merge(st_r.grp_map[2], wr_data, wr_strb);
            `IAR_IDX_FEATURE: begin
               if (wr_strb[0]) begin
                  st_nxt.mode_full = wr_data[`IAR_MODE_BIT];
               end
            end
            `IAR_IDX_PIN_MAP_A: st_nxt.pin_map[0] = merge(st_r.pin_map[0], wr_data, wr_strb);
            `IAR_IDX_PIN_MAP_B: st_nxt.pin_map[1] = merge(st_r.pin_map[1], wr_data, wr_strb);
            `IAR_IDX_PIN_MAP_C: st_nxt.pin_map[2] = merge(st_r.pin_map[2], wr_data, wr_strb);
            `IAR_IDX_INT_SRC_MAP: st_nxt.int_src_map = merge(st_r.int_src_map, wr_data, wr_strb);
            `IAR_IDX_EVT_ENABLE: st_nxt.evt_enable = merge(st_r.evt_enable, wr_data, wr_strb);
            `IAR_IDX_EVT_CLEAR: clr = merge(`IAR_WORD_ZERO, wr_data, wr_strb);
            default: clr = '0;
         endcase
      end
      st_nxt.pins = routed;
      // A pin that rises in the cycle its bit is cleared stays recorded.
      st_nxt.evt_status = (st_r.evt_status & ~clr) | (routed & ~st_r.pins);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.mode_full <= `IAR_MODE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign irq_pin = st_r.pins;
   assign irq_out = |(st_r.evt_status & st_r.evt_enable);
endmodule

//--- common/iar_regs.svh
// Purpose: Register indices, field positions, reset values of the interrupt routing front end.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef IAR_REGS_SVH
`define IAR_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IAR_IDX_GRP_MAP_0    6'h10
`define IAR_IDX_GRP_MAP_1    6'h11
`define IAR_IDX_GRP_MAP_2    6'h12
`define IAR_IDX_FEATURE      6'h13
`define IAR_IDX_PIN_MAP_A    6'h06
`define IAR_IDX_PIN_MAP_B    6'h07
`define IAR_IDX_PIN_MAP_C    6'h08
`define IAR_IDX_INT_SRC_MAP  6'h09
`define IAR_IDX_DEBUG_STS    6'h0A
`define IAR_IDX_EVT_STATUS   6'h14
`define IAR_IDX_EVT_ENABLE   6'h15
`define IAR_IDX_EVT_CLEAR    6'h16

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define IAR_FLD_STRIDE       8
`define IAR_PIN_LSB          0
`define IAR_GRP_LSB          0
`define IAR_SWZ_LSB          4
`define IAR_HOST_LINK_LSB    0
`define IAR_XLATE_LSB        8
`define IAR_MODE_BIT         0
`define IAR_FULL_GROUPS      4'h8
`define IAR_REDUCED_GROUPS   4'h6
`define IAR_FULL_PINS        6'h20
`define IAR_REDUCED_PINS     6'h18
`define IAR_NUM_EXT_GROUPS   11
`define IAR_NUM_BRIDGES      12

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define IAR_MAP_RST          32'h0000_0000
`define IAR_MODE_RST         1'b1
`define IAR_DBG_INV_MASK     32'h0000_00F0
`define IAR_WORD_ZERO        32'h0000_0000

`endif

//--- common/iar_pkg.sv
// Purpose: Shared types of the interrupt routing front end.
// Assumes: Constants live in iar_regs.svh.
// Notes: Types only.
package iar_pkg;
   typedef logic [4:0] iar_pin_t;
   typedef logic [2:0] iar_grp_t;
   typedef logic [1:0] iar_swz_t;
   typedef enum logic [1:0] {
      IAR_RESP_OKAY = 2'h0,
      IAR_RESP_SLVERR = 2'h2
   } iar_resp_t;
endpackage

//--- rtl/iar_swizzle.sv
// Purpose: Reorders one four-wire interrupt group by its swizzle code.
// Assumes: Wire A is bit 0 and wire D is bit 3.
// Notes: Purely combinational.
`timescale 1ns/1ps
module iar_swizzle (
   input wire logic [3:0] group_in,
   input wire iar_pkg::iar_swz_t swizzle_code,
   output logic [3:0] group_out
);
   // Code n places wire n of the incoming group in the low position, so the
   // four codes give ABCD, BCDA, CDAB and DABC.
   function automatic logic [3:0] rotate(input logic [3:0] v, input iar_pkg::iar_swz_t c);
      logic [7:0] twice;
      twice = {v, v};
      rotate = twice[c +: 4];
   endfunction

   always_comb begin
      group_out = rotate(group_in, swizzle_code);
   end
endmodule

//--- rtl/iar_axil_slave.sv
// Purpose: AXI4-Lite slave front end handing single-word accesses to the register file.
// Assumes: Register file decodes the address and answers combinationally.
// Notes: One write and one read may be under way at a time.
`timescale 1ns/1ps
module iar_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [5:0] wr_idx,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [5:0] rd_idx,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   typedef struct packed {
      logic aw_full;
      logic [5:0] aw_idx;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_valid;
      iar_pkg::iar_resp_t b_resp;
      logic r_valid;
      logic [31:0] r_data;
      iar_pkg::iar_resp_t r_resp;
   } iar_axs_t;

   iar_axs_t st_r;
   iar_axs_t st_nxt;

   assign s_axi_awready = !st_r.aw_full;
   assign s_axi_wready = !st_r.w_full;
   assign s_axi_arready = !st_r.r_valid;
   assign s_axi_bvalid = st_r.b_valid;
   assign s_axi_bresp = st_r.b_resp;
   assign s_axi_rvalid = st_r.r_valid;
   assign s_axi_rdata = st_r.r_data;
   assign s_axi_rresp = st_r.r_resp;

   // The write is issued only once the previous response has been taken, so
   // the register file never sees a write whose answer could be lost.
   assign wr_en = st_r.aw_full && st_r.w_full && !st_r.b_valid;
   assign wr_idx = st_r.aw_idx;
   assign wr_data = st_r.w_data;
   assign wr_strb = st_r.w_strb;
   assign rd_idx = s_axi_araddr[7:2];

   always_comb begin
      st_nxt = st_r;
      if (s_axi_awvalid && !st_r.aw_full) begin
         st_nxt.aw_full = 1'b1;
         st_nxt.aw_idx = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !st_r.w_full) begin
         st_nxt.w_full = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (st_r.b_valid && s_axi_bready) begin
         st_nxt.b_valid = 1'b0;
      end
      if (wr_en) begin
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full = 1'b0;
         st_nxt.b_valid = 1'b1;
         st_nxt.b_resp = wr_ok ? iar_pkg::IAR_RESP_OKAY : iar_pkg::IAR_RESP_SLVERR;
      end
      if (st_r.r_valid && s_axi_rready) begin
         st_nxt.r_valid = 1'b0;
      end
      if (s_axi_arvalid && !st_r.r_valid) begin
         st_nxt.r_valid = 1'b1;
         st_nxt.r_data = rd_data;
         st_nxt.r_resp = rd_ok ? iar_pkg::IAR_RESP_OKAY : iar_pkg::IAR_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

//--- test/iar_monitor.sv
// Purpose: Port-level checks of the interrupt routing front end.
// Assumes: One clock, synchronous active-low reset, bus master holds ready low at first.
// Notes: Bound to iar_routing_top below.
`timescale 1ns/1ps
module iar_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [43:0] ext_group_irq,
   input wire logic [11:0] bridge_irq,
   input wire logic host_link_irq,
   input wire logic translation_unit_irq,
   input wire logic [31:0] irq_pin,
   input wire logic irq_out
);
   // ------------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Reset itself is the cause here, so this one must not be disabled by it.
   a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> irq_pin == 32'h0000_0000 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not quiet after reset");
   a_ready_release: assert property ($rose(aresetn) |->
      s_axi_awready && s_axi_wready && s_axi_arready)
      else $error("bus not ready after reset");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   a_idle_pins: assert property (ext_group_irq == 44'h000_0000_0000 &&
      bridge_irq == 12'h000 && !host_link_irq && !translation_unit_irq
      |=> irq_pin == 32'h0000_0000)
      else $error("pin driven with no source active");
   a_irq_fall_cause: assert property ($fell(irq_out) |-> $rose(s_axi_bvalid))
      else $error("interrupt dropped without a register write");
endmodule

bind iar_routing_top iar_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .ext_group_irq(ext_group_irq), .bridge_irq(bridge_irq), .host_link_irq(host_link_irq),
   .translation_unit_irq(translation_unit_irq), .irq_pin(irq_pin), .irq_out(irq_out));

//--- test/iar_src_model.sv
// Purpose: On-chip interrupt sources feeding the routing front end.
// Assumes: Sources are level signals on aclk.
// Notes: New levels are taken on a load strobe, so they change right after an edge.
`timescale 1ns/1ps
module iar_src_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ld,
   input wire logic [43:0] ext_d,
   input wire logic [11:0] br_d,
   input wire logic hl_d,
   input wire logic tu_d,
   output logic [43:0] ext_group_irq,
   output logic [11:0] bridge_irq,
   output logic host_link_irq,
   output logic translation_unit_irq
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {ext_group_irq, bridge_irq, host_link_irq, translation_unit_irq} <= '0;
      end else if (ld) begin
         {ext_group_irq, bridge_irq, host_link_irq, translation_unit_irq} <=
            {ext_d, br_d, hl_d, tu_d};
      end
   end
endmodule

//--- test/tb_ioapic_interrupt_routing.sv
// Purpose: Register-level tests of pin routing, swizzle, group and event logic.
// Assumes: Source levels settle on the pins two edges after they are loaded.
// Notes: Bridge port p is steered to pin 2p+1 so every port lands on its own pin.
`timescale 1ns/1ps
`include "iar_regs.svh"
module tb_ioapic_interrupt_routing;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic ld = 1'b0, hl_d = 1'b0, tu_d = 1'b0;
   logic [43:0] ext_d = 44'h000_0000_0000;
   logic [11:0] br_d = 12'h000;
   logic awready, wready, bvalid, arready, rvalid, irq_out, hl, tu;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, irq_pin;
   logic [43:0] ext;
   logic [11:0] br;
   int failures = 0;
   int n_tests = 0;
   always #12.5 aclk = ~aclk;
   iar_src_model src_u (.aclk(aclk), .aresetn(aresetn), .ld(ld), .ext_d(ext_d), .br_d(br_d),
      .hl_d(hl_d), .tu_d(tu_d), .ext_group_irq(ext), .bridge_irq(br), .host_link_irq(hl),
      .translation_unit_irq(tu));
   iar_routing_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_group_irq(ext), .bridge_irq(br), .host_link_irq(hl), .translation_unit_irq(tu),
      .irq_pin(irq_pin), .irq_out(irq_out));
   // ------------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic chk_r(input logic [1:0] e, input logic [1:0] g);
      chk("resp", {30'h0, e}, {30'h0, g});
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Ready is raised only after the answer shows, so the hold checks see a stall.
   // Outputs are looked at on the falling edge, where they have settled and
   // still hold the value that the next rising edge samples.
   task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, a, b;
      logic [1:0] resp;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(negedge aclk);
         a = awready === 1'b1;
         b = wready === 1'b1;
         @(posedge aclk);
         if (!aw_ok && a) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && b) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      @(negedge aclk);
      while (bvalid !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      bready <= 1'b1;
      @(negedge aclk);
      resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
      chk_r(er, resp);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] data;
      logic [1:0] resp;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      @(negedge aclk);
      while (arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      arvalid <= 1'b0;
      @(negedge aclk);
      while (rvalid !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      rready <= 1'b1;
      @(negedge aclk);
      data = rdata;
      resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      chk("read", e, data);
      chk_r(er, resp);
   endtask
   task automatic put(input logic [43:0] e, input logic [11:0] b, input logic h, input logic t);
      ext_d <= e;
      br_d <= b;
      hl_d <= h;
      tu_d <= t;
      ld <= 1'b1;
      @(posedge aclk);
      ld <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      #(25 * 20000);
      failures++;
      report_and_stop();
   end
   initial begin
      logic [31:0] m;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 6; i < 10; i++) rd(6'(i), `IAR_MAP_RST, 2'h0);
      rd(`IAR_IDX_FEATURE, 32'h0000_0001, 2'h0);
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 4; j++) m[8*j +: 8] = 8'(8*k + 2*j + 1);
         wr(6'(6 + k), m, 2'h0);
         rd(6'(6 + k), m, 2'h0);
      end
      for (int p = 0; p < 12; p++) begin
         put(44'h0, 12'(1 << p), 1'b0, 1'b0);
         chk("bridge pin", 32'h1 << (2 * p + 1), irq_pin);
      end
      wr(`IAR_IDX_INT_SRC_MAP, 32'h0000_1E07, 2'h0);
      put(44'h0, 12'h000, 1'b1, 1'b0);
      chk("host pin", 32'h0000_0080, irq_pin);
      put(44'h0, 12'h000, 1'b0, 1'b1);
      chk("xlate pin", 32'h4000_0000, irq_pin);
      put(44'h0, 12'hFFF, 1'b1, 1'b1);
      chk("all pins", 32'h40AA_AAAA | 32'h0000_0080, irq_pin);
      wr(`IAR_IDX_INT_SRC_MAP, 32'h0000_1E01, 2'h0);
      put(44'h0, 12'h001, 1'b1, 1'b0);
      chk("shared pin", 32'h0000_0002, irq_pin);
      rd(`IAR_IDX_DEBUG_STS, 32'h0000_0002 ^ `IAR_DBG_INV_MASK, 2'h0);
      wr(`IAR_IDX_DEBUG_STS, 32'hFFFF_FFFF, 2'h2);
      rd(6'h3F, 32'h0000_0000, 2'h2);
      for (int c = 0; c < 4; c++) begin
         wr(`IAR_IDX_GRP_MAP_0, 32'(16 * c + 3), 2'h0);
         put(44'h1, 12'h000, 1'b0, 1'b0);
         chk("swizzle", 32'h1 << (8 + (4 - c) % 4), irq_pin);
      end
      wr(`IAR_IDX_GRP_MAP_0, 32'h0000_1202, 2'h0);
      put(44'h11, 12'h000, 1'b0, 1'b0);
      chk("group share", 32'h0000_0090, irq_pin);
      wr(`IAR_IDX_GRP_MAP_2, 32'h0000_0000, 2'h0);
      put(44'hF00_0000_0000, 12'h000, 1'b0, 1'b0);
      chk("group 8", 32'hF000_0000, irq_pin);
      wr(`IAR_IDX_FEATURE, 32'h0000_0000, 2'h0);
      chk("reduced drop", 32'h0000_0000, irq_pin);
      wr(`IAR_IDX_GRP_MAP_2, 32'h0006_0000, 2'h0);
      chk("reduced 6", 32'h00F0_0000, irq_pin);
      wr(`IAR_IDX_FEATURE, 32'h0000_0001, 2'h0);
      wr(`IAR_IDX_EVT_CLEAR, 32'hFFFF_FFFF, 2'h0);
      rd(`IAR_IDX_EVT_STATUS, 32'h0000_0000, 2'h0);
      wr(`IAR_IDX_EVT_ENABLE, 32'h0000_0002, 2'h0);
      put(44'h0, 12'h000, 1'b1, 1'b0);
      chk("irq raised", 32'h1, {31'h0, irq_out});
      rd(`IAR_IDX_EVT_STATUS, 32'h0000_0002, 2'h0);
      wr(`IAR_IDX_EVT_ENABLE, 32'h0000_0000, 2'h0);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      wr(`IAR_IDX_EVT_ENABLE, 32'h0000_0002, 2'h0);
      chk("irq unmasked", 32'h1, {31'h0, irq_out});
      wr(`IAR_IDX_EVT_CLEAR, 32'h0000_0002, 2'h0);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      rd(`IAR_IDX_EVT_STATUS, 32'h0000_0000, 2'h0);
      report_and_stop();
   end
endmodule
